// ==== shared/qwpp_pkg.sv ====
// Constants, opcodes and timing for the quad wrap read and page program sequencer.
// Assumes a 40 MHz system clock that oversamples the serial bus pins.
package qwpp_pkg;
   // Opcodes
   localparam logic [7:0] OP_WRITE_ENABLE   = 8'h06;
   localparam logic [7:0] OP_READ_STATUS    = 8'h05;
   localparam logic [7:0] OP_SET_WRAP       = 8'h77;
   localparam logic [7:0] OP_QUAD_FAST_READ = 8'hEB;
   localparam logic [7:0] OP_WORD_READ      = 8'hE7;
   localparam logic [7:0] OP_OCTAL_READ     = 8'hE3;
   localparam logic [7:0] OP_PAGE_PROGRAM   = 8'h02;
   // Frame lengths in serial clocks
   localparam int unsigned QUAD_ADDR_CLKS   = 6;
   localparam int unsigned SER_ADDR_BITS    = 24;
   localparam int unsigned MODE_CLKS        = 2;
   localparam int unsigned WRAP_CMD_BITS    = 32;
   localparam int unsigned DUMMY_FAST_READ  = 4;
   localparam int unsigned DUMMY_WORD_READ  = 2;
   localparam int unsigned DUMMY_OCTAL_READ = 0;
   localparam int unsigned PAGE_BYTES       = 256;
   localparam int unsigned WRAP_BASE_BYTES  = 8;
   // Field positions
   localparam int unsigned STAT_BUSY_POS    = 0;
   localparam int unsigned STAT_LATCH_POS   = 1;
   localparam int unsigned WRAP_DIS_POS     = 4;
   localparam int unsigned WRAP_LEN_LO_POS  = 5;
   localparam logic [1:0]  CONT_MODE_CODE   = 2'h2;
   // Values after reset
   localparam logic        WRAP_DIS_RST     = 1'h1;
   localparam logic [1:0]  WRAP_LEN_RST     = 2'h0;
   localparam logic [5:0]  PIN_SYNC_RST     = 6'h20;
   localparam logic [7:0]  ERASED_BYTE      = 8'hFF;
   // Program cycle timing
   localparam int unsigned CLK_PERIOD_NS    = 25;
   localparam int unsigned PROG_TIME_NS     = 400000;
   localparam int unsigned PROG_CYCLES_DEF  = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned BLOCK_PAGES_DEF  = 2;
endpackage : qwpp_pkg

// ==== shared/qwpp_store_if.sv ====
// Link between the sequencer and its byte store and page buffer.
// Assumes both ends run on the same system clock.
interface qwpp_store_if #(parameter int unsigned AW = 10);
   logic [AW-1:0] rd_addr;
   logic [7:0]    rd_data;
   logic          buf_clear;
   logic          buf_wr;
   logic [7:0]    buf_idx;
   logic [7:0]    buf_data;
   logic          commit;
   logic [AW-9:0] commit_page;
   logic [7:0]    commit_idx;
   modport ctrl  (output rd_addr, buf_clear, buf_wr, buf_idx, buf_data, commit, commit_page, commit_idx,
                  input rd_data);
   modport store (input rd_addr, buf_clear, buf_wr, buf_idx, buf_data, commit, commit_page, commit_idx,
                  output rd_data);
endinterface : qwpp_store_if

// ==== src/qwpp_pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter.
// Assumes asynchronous inputs; output moves only when stages two and three agree.
module qwpp_pin_sync #(
   parameter int unsigned       WIDTH   = 6,
   parameter logic [WIDTH-1:0]  RST_VAL = '0
) (
   input  wire logic             clock_in,
   input  wire logic             sys_rst_in,
   input  wire logic [WIDTH-1:0] pins_in,
   output logic      [WIDTH-1:0] pins_out
);
   logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
   logic [WIDTH-1:0] out_d;

   // Per bit, accept a level once two stages match
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
      end
   end

   // First stage feeds only the second
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         s1_q  <= RST_VAL;
         s2_q  <= RST_VAL;
         s3_q  <= RST_VAL;
         out_q <= RST_VAL;
      end else begin
         s1_q  <= pins_in;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         out_q <= out_d;
      end
   end

   assign pins_out = out_q;
endmodule : qwpp_pin_sync

// ==== src/qwpp_store.sv ====
// Byte array in flip-flops plus the one-page program buffer.
// Assumes the sequencer never clears and writes the buffer in one cycle.
module qwpp_store
   import qwpp_pkg::*;
#(
   parameter int unsigned NUM_PAGES = 4
) (
   input  wire logic     clock_in,
   input  wire logic     sys_rst_in,
   qwpp_store_if.store   st_if
);
   localparam int unsigned BYTES = NUM_PAGES * PAGE_BYTES;
   logic [7:0] mem_q [BYTES];
   logic [7:0] mem_d [BYTES];
   logic [7:0] buf_q [PAGE_BYTES];
   logic [7:0] buf_d [PAGE_BYTES];

   // Buffer fill and bitwise program commit
   always_comb begin
      mem_d = mem_q;
      buf_d = buf_q;
      if (st_if.buf_clear) begin
         for (int i = 0; i < PAGE_BYTES; i++) begin
            buf_d[i] = ERASED_BYTE;
         end
      end else if (st_if.buf_wr) begin
         buf_d[st_if.buf_idx] = st_if.buf_data;
      end
      if (st_if.commit) begin
         // AND keeps ones in the data from touching the cell
         mem_d[{st_if.commit_page, st_if.commit_idx}] =
            mem_q[{st_if.commit_page, st_if.commit_idx}] & buf_q[st_if.commit_idx];
      end
   end

   // Reset leaves the array erased; a model, not a retentive cell
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         for (int i = 0; i < BYTES; i++) begin
            mem_q[i] <= ERASED_BYTE;
         end
         for (int i = 0; i < PAGE_BYTES; i++) begin
            buf_q[i] <= ERASED_BYTE;
         end
      end else begin
         mem_q <= mem_d;
         buf_q <= buf_d;
      end
   end

   assign st_if.rd_data = mem_q[st_if.rd_addr];
endmodule : qwpp_store

// ==== src/qwpp_top.sv ====
// Serial flash command sequencer: quad reads with wrap and continuous mode, page program.
// Assumes bus pins arrive asynchronously and the serial clock is well below the system clock.
module qwpp_top
   import qwpp_pkg::*;
#(
   parameter int unsigned NUM_PAGES   = 4,
   parameter int unsigned BLOCK_PAGES = BLOCK_PAGES_DEF,
   parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF
) (
   input  wire logic                 clock_in,
   input  wire logic                 sys_rst_in,
   input  wire logic                 cs_n_in,
   input  wire logic                 sclk_in,
   input  wire logic [3:0]           io_in,
   output logic      [3:0]           io_out,
   output logic      [3:0]           io_oe_out,
   input  wire logic                 quad_lane_enable_in,
   input  wire logic                 four_lane_command_mode_in,
   input  wire logic                 read_param_load_in,
   input  wire logic [1:0]           read_param_len_in,
   input  wire logic [2:0]           protect_level_in,
   input  wire logic                 protect_top_bottom_in,
   input  wire logic                 protect_granularity_in,
   input  wire logic                 protect_complement_in,
   input  wire logic [NUM_PAGES-1:0] page_lock_in,
   output logic                      busy_out,
   output logic                      write_latch_flag_out,
   output logic      [2:0]           wrap_setting_bits_out
);
   localparam int unsigned AW = $clog2(NUM_PAGES * PAGE_BYTES);
   localparam int unsigned PW = AW - 8;
   localparam int unsigned CW = $clog2(PROG_CYCLES + 1);

   typedef enum logic [3:0] {
      S_CMD, S_ADDR, S_MODE, S_DUMMY, S_DATA, S_STATUS, S_WRAP, S_PP_DATA, S_IGNORE
   } qwpp_state_e;

   qwpp_store_if #(.AW(AW)) st_if ();

   qwpp_store #(.NUM_PAGES(NUM_PAGES)) i_qwpp_store (
      .clock_in   (clock_in),
      .sys_rst_in (sys_rst_in),
      .st_if      (st_if)
   );

   logic [5:0] pins_s;
   qwpp_pin_sync #(.WIDTH(6), .RST_VAL(PIN_SYNC_RST)) i_qwpp_pin_sync (
      .clock_in   (clock_in),
      .sys_rst_in (sys_rst_in),
      .pins_in    ({cs_n_in, sclk_in, io_in}),
      .pins_out   (pins_s)
   );

   logic        cs_n_s, sclk_s;
   logic [3:0]  io_s;
   logic        sclk_prev_q, cs_prev_q;
   logic        sclk_rise, sclk_fall, cs_rise;
   assign {cs_n_s, sclk_s, io_s} = pins_s;
   assign sclk_rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
   assign sclk_fall = ~sclk_s & sclk_prev_q & ~cs_n_s;
   assign cs_rise   = cs_n_s & ~cs_prev_q;

   qwpp_state_e  st_q, st_d;
   logic [4:0]   cnt_q, cnt_d;
   logic [23:0]  sh_q, sh_d;
   logic [7:0]   byte_q, byte_d;
   logic [7:0]   op_q, op_d;
   logic         cont_q, cont_d;
   logic [AW-1:0] addr_q, addr_d;
   logic         nib_q, nib_d;
   logic [3:0]   io_out_q, io_out_d, io_oe_q, io_oe_d;
   logic         wrap_dis_q, wrap_dis_d;
   logic [1:0]   wrap_len_q, wrap_len_d;
   logic         wel_q, wel_d, busy_q, busy_d;
   logic [CW-1:0] pcnt_q, pcnt_d;
   logic [PW-1:0] page_q, page_d;
   logic [7:0]   idx_q, idx_d;
   logic [2:0]   bits_q, bits_d;
   logic         any_q, any_d;
   logic         buf_clear, buf_wr;
   logic [7:0]   status_byte;
   logic [4:0]   dummy_clks;
   logic         wrap_act, prot_hit;
   logic [AW-1:0] sect_mask, addr_inc, next_addr;

   // Page protection from level, side, unit size, complement and locks
   function automatic logic page_protected(input logic [PW-1:0] pg);
      int unsigned span, unit;
      logic hit;
      unit = protect_granularity_in ? 1 : BLOCK_PAGES;
      span = (protect_level_in == 3'h0) ? 0 : ((1 << (protect_level_in - 3'h1)) * unit);
      if (protect_top_bottom_in) begin
         hit = (int'(pg) < span);
      end else begin
         hit = (int'(pg) + span >= NUM_PAGES);
      end
      return (hit ^ protect_complement_in) | page_lock_in[pg];
   endfunction : page_protected

   // Read address stepping, section-limited when wrap is active
   always_comb begin
      status_byte = 8'h00;
      status_byte[STAT_BUSY_POS]  = busy_q;
      status_byte[STAT_LATCH_POS] = wel_q;
      case (op_q)
         OP_QUAD_FAST_READ: dummy_clks = 5'(DUMMY_FAST_READ);
         OP_WORD_READ:      dummy_clks = 5'(DUMMY_WORD_READ);
         default:           dummy_clks = 5'(DUMMY_OCTAL_READ);
      endcase
      // Single-lane wrap setting is not used in four-lane command mode
      wrap_act  = ~wrap_dis_q & ~four_lane_command_mode_in &
                  ((op_q == OP_QUAD_FAST_READ) | (op_q == OP_WORD_READ));
      sect_mask = AW'((WRAP_BASE_BYTES << wrap_len_q) - 1);
      addr_inc  = addr_q + AW'(1);
      next_addr = wrap_act ? ((addr_q & ~sect_mask) | (addr_inc & sect_mask)) : addr_inc;
      prot_hit  = page_protected(page_q);
   end

   // Frame sequencing, program cycle and configuration
   always_comb begin
      st_d = st_q;   cnt_d = cnt_q;   sh_d = sh_q;   byte_d = byte_q;
      op_d = op_q;   cont_d = cont_q; addr_d = addr_q; nib_d = nib_q;
      io_out_d = io_out_q;  io_oe_d = io_oe_q;
      wrap_dis_d = wrap_dis_q;  wrap_len_d = wrap_len_q;
      wel_d = wel_q;  busy_d = busy_q;  pcnt_d = pcnt_q;
      page_d = page_q;  idx_d = idx_q;  bits_d = bits_q;  any_d = any_q;
      buf_clear = 1'b0;
      buf_wr    = 1'b0;
      if (read_param_load_in) begin
         wrap_len_d = read_param_len_in;
      end
      // Self-timed program; first page-size cycles commit bytes
      if (busy_q) begin
         if (pcnt_q == CW'(PROG_CYCLES - 1)) begin
            busy_d = 1'b0;
            wel_d  = 1'b0;
         end else begin
            pcnt_d = pcnt_q + CW'(1);
         end
      end
      if (cs_rise) begin
         // Only a whole final byte with something to write starts the cycle
         if ((st_q == S_PP_DATA) && (bits_q == 3'h0) && any_q && !prot_hit) begin
            busy_d = 1'b1;
            pcnt_d = '0;
         end
         st_d    = (cont_q && !busy_q) ? S_ADDR : S_CMD;
         cnt_d   = 5'h00;
         nib_d   = 1'b0;
         io_oe_d = 4'h0;
      end else if (sclk_rise) begin
         case (st_q)
            S_CMD: begin
               byte_d = {byte_q[6:0], io_s[0]};
               cnt_d  = cnt_q + 5'h01;
               if (cnt_q == 5'h07) begin
                  cnt_d = 5'h00;
                  op_d  = byte_d;
                  if (busy_q) begin
                     st_d = (byte_d == OP_READ_STATUS) ? S_STATUS : S_IGNORE;
                  end else begin
                     case (byte_d)
                        OP_WRITE_ENABLE: begin
                           wel_d = 1'b1;
                           st_d  = S_IGNORE;
                        end
                        OP_READ_STATUS:  st_d = S_STATUS;
                        OP_SET_WRAP:     st_d = S_WRAP;
                        OP_QUAD_FAST_READ, OP_WORD_READ, OP_OCTAL_READ: begin
                           st_d = quad_lane_enable_in ? S_ADDR : S_IGNORE;
                        end
                        OP_PAGE_PROGRAM: st_d = wel_q ? S_ADDR : S_IGNORE;
                        default:         st_d = S_IGNORE;
                     endcase
                  end
               end
            end
            S_ADDR: begin
               cnt_d = cnt_q + 5'h01;
               if (op_q == OP_PAGE_PROGRAM) begin
                  sh_d = {sh_q[22:0], io_s[0]};
                  if (cnt_q == 5'(SER_ADDR_BITS - 1)) begin
                     page_d    = sh_d[AW-1:8];
                     idx_d     = sh_d[7:0];
                     bits_d    = 3'h0;
                     any_d     = 1'b0;
                     buf_clear = 1'b1;
                     st_d      = S_PP_DATA;
                  end
               end else begin
                  sh_d = {sh_q[19:0], io_s};
                  if (cnt_q == 5'(QUAD_ADDR_CLKS - 1)) begin
                     addr_d = sh_d[AW-1:0];
                     cnt_d  = 5'h00;
                     st_d   = S_MODE;
                  end
               end
            end
            S_MODE: begin
               cnt_d = cnt_q + 5'h01;
               if (cnt_q == 5'h00) begin
                  cont_d = (io_s[1:0] == CONT_MODE_CODE);
               end
               if (cnt_q == 5'(MODE_CLKS - 1)) begin
                  // Low nibble passes unread
                  cnt_d = 5'h00;
                  st_d  = (dummy_clks == 5'h00) ? S_DATA : S_DUMMY;
               end
            end
            S_DUMMY: begin
               cnt_d = cnt_q + 5'h01;
               if (cnt_q == dummy_clks - 5'h01) begin
                  cnt_d = 5'h00;
                  st_d  = S_DATA;
               end
            end
            S_WRAP: begin
               byte_d = {byte_q[6:0], io_s[0]};
               cnt_d  = cnt_q + 5'h01;
               if (cnt_q == 5'(WRAP_CMD_BITS - 1)) begin
                  // Bit 7 and the low nibble are dropped
                  wrap_dis_d = byte_d[WRAP_DIS_POS];
                  wrap_len_d = byte_d[WRAP_LEN_LO_POS +: 2];
                  st_d       = S_IGNORE;
               end
            end
            S_PP_DATA: begin
               byte_d = {byte_q[6:0], io_s[0]};
               bits_d = bits_q + 3'h1;
               if (bits_q == 3'h7) begin
                  buf_wr = 1'b1;
                  idx_d  = idx_q + 8'h01;
                  any_d  = 1'b1;
               end
            end
            default: ;
         endcase
      end else if (sclk_fall) begin
         case (st_q)
            S_DATA: begin
               // Lanes driven only from the first data clock on
               io_oe_d = 4'hF;
               if (!nib_q) begin
                  io_out_d = st_if.rd_data[7:4];
                  nib_d    = 1'b1;
               end else begin
                  io_out_d = st_if.rd_data[3:0];
                  nib_d    = 1'b0;
                  addr_d   = next_addr;
               end
            end
            S_STATUS: begin
               // Status repeats live every eight clocks, so busy can be polled
               io_oe_d  = 4'h2;
               io_out_d = {2'h0, status_byte[3'h7 - cnt_q[2:0]], 1'h0};
               cnt_d    = {2'h0, cnt_q[2:0] + 3'h1};
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         st_q <= S_CMD;   cnt_q <= 5'h00;   sh_q <= 24'h000000;   byte_q <= 8'h00;
         op_q <= 8'h00;   cont_q <= 1'b0;   addr_q <= '0;   nib_q <= 1'b0;
         io_out_q <= 4'h0;   io_oe_q <= 4'h0;
         wrap_dis_q <= WRAP_DIS_RST;
         wrap_len_q <= WRAP_LEN_RST;
         wel_q <= 1'b0;   busy_q <= 1'b0;   pcnt_q <= '0;
         page_q <= '0;   idx_q <= 8'h00;   bits_q <= 3'h0;   any_q <= 1'b0;
         sclk_prev_q <= 1'b0;   cs_prev_q <= 1'b1;
      end else begin
         st_q <= st_d;   cnt_q <= cnt_d;   sh_q <= sh_d;   byte_q <= byte_d;
         op_q <= op_d;   cont_q <= cont_d;   addr_q <= addr_d;   nib_q <= nib_d;
         io_out_q <= io_out_d;   io_oe_q <= io_oe_d;
         wrap_dis_q <= wrap_dis_d;   wrap_len_q <= wrap_len_d;
         wel_q <= wel_d;   busy_q <= busy_d;   pcnt_q <= pcnt_d;
         page_q <= page_d;   idx_q <= idx_d;   bits_q <= bits_d;   any_q <= any_d;
         sclk_prev_q <= sclk_s;   cs_prev_q <= cs_n_s;
      end
   end

   // Store hookup; commit walks the page during the busy phase
   assign st_if.rd_addr     = addr_q;
   assign st_if.buf_clear   = buf_clear;
   assign st_if.buf_wr      = buf_wr;
   assign st_if.buf_idx     = idx_q;
   assign st_if.buf_data    = byte_d;
   assign st_if.commit      = busy_q && (pcnt_q < CW'(PAGE_BYTES));
   assign st_if.commit_page = page_q;
   assign st_if.commit_idx  = pcnt_q[7:0];

   assign io_out                = io_out_q;
   assign io_oe_out             = io_oe_q;
   assign busy_out              = busy_q;
   assign write_latch_flag_out  = wel_q;
   assign wrap_setting_bits_out = {wrap_len_q, wrap_dis_q};

   // Checks
   a_latch_clear_done: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      $fell(busy_q) |-> !wel_q) else $error("latch not cleared after program");
   a_prog_needs_latch: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      $rose(busy_q) |-> $past(wel_q)) else $error("program without latch");
   a_prog_not_protected: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      $rose(busy_q) |-> !$past(prot_hit)) else $error("protected page programmed");
   a_prog_whole_byte: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      $rose(busy_q) |-> ($past(bits_q) == 3'h0) && $past(cs_rise)) else $error("partial byte programmed");
   a_busy_holds_min: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      $rose(busy_q) |-> busy_q[*8]) else $error("busy dropped early");
   a_wrap_reset_off: assert property (@(posedge clock_in)
      sys_rst_in |=> wrap_dis_q && !busy_q) else $error("wrap not disabled by reset");
   a_busy_ignores_ops: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (sclk_rise && st_q == S_CMD && cnt_q == 5'h07 && busy_q && !cs_rise)
      |=> (st_q == S_STATUS) || (st_q == S_IGNORE)) else $error("command taken while busy");
   a_wrap_in_section: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (st_q == S_DATA && wrap_act && sclk_fall && nib_q && !cs_rise)
      |=> (addr_q & ~sect_mask) == ($past(addr_q) & ~sect_mask)) else $error("wrap left section");
   a_cont_skips_op: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (cs_rise && cont_q && !busy_q) |=> st_q == S_ADDR) else $error("continuous frame expected opcode");
   a_octal_no_dummy: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (sclk_rise && !cs_rise && st_q == S_MODE && cnt_q == 5'h01 && op_q == OP_OCTAL_READ)
      |=> st_q == S_DATA) else $error("octal read waited for dummies");
   a_page_fixed: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      (st_q == S_PP_DATA) ##1 (st_q == S_PP_DATA) |-> $stable(page_q)) else $error("page moved");

   c_wrapped_read: cover property (@(posedge clock_in) disable iff (sys_rst_in)
      st_q == S_DATA && wrap_act && sclk_fall && nib_q);
   c_page_program: cover property (@(posedge clock_in) disable iff (sys_rst_in) $fell(busy_q));
   c_cont_frame: cover property (@(posedge clock_in) disable iff (sys_rst_in) cs_rise && cont_q);
   c_status_poll: cover property (@(posedge clock_in) disable iff (sys_rst_in) st_q == S_STATUS && busy_q);
endmodule : qwpp_top

// ==== tb/qwpp_host.sv ====
// Host model: frames on the serial bus, one clock per clk or get call, eight per put.
// Assumes the bench resolves lanes from both enables.
module qwpp_host (
   input  wire logic       clock_in,
   input  wire logic [3:0] io_in,
   output logic            cs_n_out,
   output logic            sclk_out,
   output logic      [3:0] io_out,
   output logic            io_en_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      cs_n_out = 1'h1;
      sclk_out = 1'h0;
      io_out = 4'h0;
      io_en_out = 1'h0;
   end
   // Lanes change while the clock is low
   task automatic clk(input logic [3:0] v);
      sclk_out = 1'h0;
      io_out = v;
      io_en_out = 1'h1;
      #100 sclk_out = 1'h1;
      #100;
   endtask : clk
   task automatic put(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) clk({3'h0, b[i]});
   endtask : put
   // Lanes let go as the clock falls; sample late, the device output lags the fall
   task automatic get(output logic [3:0] v);
      io_en_out = 1'h0;
      sclk_out = 1'h0;
      #100 sclk_out = 1'h1;
      #90 v = io_in;
      #10;
   endtask : get
   task automatic go;
      @(posedge clock_in);
      #2 cs_n_out = 1'h0;
      #100;
   endtask : go
   // Clock stands low between frames
   task automatic stop;
      sclk_out = 1'h0;
      #100 cs_n_out = 1'h1;
      io_en_out = 1'h0;
      #400;
   endtask : stop
endmodule : qwpp_host

// ==== tb/test_qwpp_top.sv ====
// Bench: host model frames against the sequencer top.
// Assumes the array resets to all ones and a short program time.
module test_qwpp_top;
   timeunit 1ns;
   timeprecision 100ps;
   import qwpp_pkg::*;
   logic       clk = 1'h0, rst = 1'h1, tog = 1'h0, qe = 1'h1, busy, write_latch_flag, h_en, h_cs, h_sck;
   logic       flm = 1'h0, rpl = 1'h0, ptb = 1'h0, pgr = 1'h1, pcp = 1'h0;
   logic [1:0] rpn = 2'h0;
   logic [2:0] pl = 3'h0, wb;
   logic [3:0] io, io_dev, oe, h_io, lk = 4'h0;
   int         error_cnt = 0, checked = 0;
   // Released lanes toggle so stale values never match
   assign io = (oe & io_dev) | (~oe & (h_en ? h_io : {4{tog}}));
   always @(posedge clk) tog <= ~tog;
   initial forever #12.5 clk = ~clk;
   qwpp_top #(.NUM_PAGES(4), .PROG_CYCLES(300)) i_qwpp_top (
      .clock_in(clk), .sys_rst_in(rst), .cs_n_in(h_cs), .sclk_in(h_sck), .io_in(io),
      .io_out(io_dev), .io_oe_out(oe), .quad_lane_enable_in(qe), .four_lane_command_mode_in(flm),
      .read_param_load_in(rpl), .read_param_len_in(rpn), .protect_level_in(pl),
      .protect_top_bottom_in(ptb), .protect_granularity_in(pgr), .protect_complement_in(pcp),
      .page_lock_in(lk), .busy_out(busy), .write_latch_flag_out(write_latch_flag), .wrap_setting_bits_out(wb));
   qwpp_host i_qwpp_host (.clock_in(clk), .io_in(io), .cs_n_out(h_cs), .sclk_out(h_sck),
      .io_out(h_io), .io_en_out(h_en));
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e) begin
         error_cnt++;
         $display("unexpected %s exp %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic final_report;
      if (error_cnt == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   task automatic pp(input logic [23:0] a, input int nb, input int xb, input logic eb);
      logic [3:0] v;
      logic [7:0] s;
      i_qwpp_host.go();
      i_qwpp_host.put(OP_PAGE_PROGRAM);
      for (int i = 0; i < 3; i++) i_qwpp_host.put(a[23-8*i -: 8]);
      for (int i = 0; i < nb; i++) i_qwpp_host.put(8'hA0 + i[7:0]);
      repeat (xb) i_qwpp_host.clk(4'h0);
      i_qwpp_host.stop();
      chk("busy", busy, eb);
      // Status must stay readable while the program cycle runs
      if (eb) begin
         i_qwpp_host.go();
         i_qwpp_host.put(OP_READ_STATUS);
         for (int i = 7; i >= 0; i--) begin
            i_qwpp_host.get(v);
            s[i] = v[1];
         end
         i_qwpp_host.stop();
         chk("status", s, 8'h03);
      end
      // Whole clock periods keep stimulus on its offset
      for (int i = 0; i < 400 && busy === 1'h1; i++) #25;
      chk("busy", busy, 1'h0);
   endtask : pp
   task automatic qr(input logic [7:0] op, input logic [23:0] a, input logic [7:0] m, input int d,
                     input logic [31:0] e);
      logic [3:0] hi, lo;
      i_qwpp_host.go();
      if (op != 8'h00) i_qwpp_host.put(op);
      for (int i = 0; i < 6; i++) i_qwpp_host.clk(a[23-4*i -: 4]);
      i_qwpp_host.clk(m[7:4]);
      i_qwpp_host.clk(m[3:0]);
      repeat (d) i_qwpp_host.clk(4'h0);
      for (int i = 0; i < 4; i++) begin
         i_qwpp_host.get(hi);
         i_qwpp_host.get(lo);
         if (qe) chk("data", {hi, lo}, e[31-8*i -: 8]);
      end
      chk("lane drive", oe, qe ? 4'hF : 4'h0);
      i_qwpp_host.stop();
   endtask : qr
   // Eight ones on lane zero end continuous mode; an opcode read must then work
   task automatic cx;
      i_qwpp_host.go();
      i_qwpp_host.put(8'hFF);
      i_qwpp_host.stop();
      qr(OP_OCTAL_READ, 24'h000000, 8'h00, 0, 32'hA1A2FFFF);
   endtask : cx
   // One-clock load of the wrap length
   task automatic rp(input logic [1:0] n, input logic [2:0] e);
      rpn = n;
      rpl = 1'h1;
      #25 rpl = 1'h0;
      #100;
      chk("wrap", wb, e);
   endtask : rp
   // Reset in mid-run with wrap enabled
   task automatic rs;
      rst = 1'h1;
      #100 rst = 1'h0;
      #200;
      chk("wrap", wb, 3'h1);
   endtask : rs
   task automatic wr(input logic [7:0] w, input logic [2:0] e);
      i_qwpp_host.go();
      i_qwpp_host.put(OP_SET_WRAP);
      repeat (3) i_qwpp_host.put(8'h00);
      i_qwpp_host.put(w);
      i_qwpp_host.stop();
      chk("wrap", wb, e);
   endtask : wr
   task automatic we;
      i_qwpp_host.go();
      i_qwpp_host.put(OP_WRITE_ENABLE);
      i_qwpp_host.stop();
      chk("latch", write_latch_flag, 1'h1);
   endtask : we
   initial begin
      repeat (4) @(posedge clk);
      #2 rst = 1'h0;
      #200;
      chk("wrap", wb, 3'h1);
      pp(24'h0000FF, 3, 0, 1'h0);
      for (int n = 0; n < 4; n++) wr({1'h1, n[1:0], 5'h0A}, {n[1:0], 1'h0});
      wr(8'h8F, 3'h0);
      we();
      pp(24'h0000FF, 3, 0, 1'h1);
      chk("latch", write_latch_flag, 1'h0);
      qr(OP_WORD_READ, 24'h000006, 8'hA0, 2, 32'hFFFFA1A2);
      qr(8'h00, 24'h000000, 8'hFF, 2, 32'hA1A2FFFF);
      qr(OP_OCTAL_READ, 24'h000000, 8'hA5, 0, 32'hA1A2FFFF);
      cx();
      qe = 1'h0;
      qr(OP_OCTAL_READ, 24'h000000, 8'h00, 0, 32'h0);
      qe = 1'h1;
      qr(OP_QUAD_FAST_READ, 24'h000006, 8'h00, 4, 32'hFFFFA1A2);
      flm = 1'h1;
      qr(OP_WORD_READ, 24'h000006, 8'h00, 2, 32'hFFFFFFFF);
      flm = 1'h0;
      rp(2'h3, 3'h6);
      we();
      pl = 3'h1;
      pp(24'h000300, 1, 0, 1'h0);
      pl = 3'h0;
      pp(24'h000100, 1, 4, 1'h0);
      pl = 3'h1;
      pgr = 1'h0;
      pp(24'h000200, 1, 0, 1'h0);
      pcp = 1'h1;
      pp(24'h0000FE, 3, 0, 1'h0);
      ptb = 1'h1;
      lk = 4'h1;
      pp(24'h0000FE, 3, 0, 1'h0);
      lk = 4'h0;
      pp(24'h0000FE, 3, 0, 1'h1);
      pl = 3'h0;
      qr(OP_OCTAL_READ, 24'h000000, 8'h00, 0, 32'hA0A2FFFF);
      rs();
      wr(8'h70, 3'h7);
      final_report();
   end
   // Watchdog well beyond the expected run
   initial begin
      #1000000;
      error_cnt++;
      final_report();
   end
endmodule : test_qwpp_top
